// ### hdl/rfs_pkg.sv
package rfs_pkg;
    // Timebase rate in kHz.
    localparam int unsigned CLK_KHZ = 200000;
    // Sample interval of the overcurrent comparator, in ns.
    localparam int unsigned OC_SAMPLE_NS = 15000;
    // Hard short response limit, in ns.
    localparam int unsigned SHORT_MAX_NS = 2000;
    // Undervoltage and overvoltage qualification time, in us.
    localparam int unsigned QUAL_US = 1000;
    // Delay from enable to start of the start-up ramp, in us.
    localparam int unsigned START_DELAY_US = 100;
    // Cycle counts derived from the times above.
    localparam int unsigned OC_SAMPLE_CYC = OC_SAMPLE_NS * (CLK_KHZ / 1000) / 1000;
    localparam int unsigned QUAL_CYC = QUAL_US * (CLK_KHZ / 1000) + 1;
    localparam int unsigned START_DELAY_CYC = START_DELAY_US * (CLK_KHZ / 1000);
    // Overcurrent counter trip count.
    localparam int unsigned OC_TRIP_COUNT = 8;
    localparam int unsigned OC_CNT_W = 4;
    localparam int unsigned TMR_W = 24;
    // Ramp source selection.
    typedef enum logic [1:0] {
        RFS_SRC_NONE,
        RFS_SRC_STARTUP,
        RFS_SRC_SLEW
    } rfs_src_t;
    // Sequencing states.
    typedef enum logic [1:0] {
        RFS_ST_OFF,
        RFS_ST_DELAY,
        RFS_ST_RAMP,
        RFS_ST_RUN
    } rfs_state_t;
endpackage : rfs_pkg

// ### hdl/rfs_supervisor.sv
// What this block does
// - Every 15 us sample overcurrent comparator; count up when over threshold.
// - At each sample below threshold, count the overcurrent counter down.
// - Latch the overcurrent fault when the counter reaches eight.
// - Hard short above 2.5x threshold latches overcurrent fault within 2 us.
// - Output 300 mV below ramp for over 1 ms latches undervoltage fault.
// - Output 195 mV above ramp for over 1 ms latches overvoltage fault.
// - Voltage qualification compares with the live ramp reference, not the code.
// - Latched overcurrent, overvoltage or undervoltage fault, without severe overvoltage, forces power good and both gates low.
// - Those faults clear only on enable drop or power-on reset.
// - Output above 1.545 V immediately latches severe overvoltage, high gate low.
// - Severe overvoltage drives low gate high above 1.545 V, low below 0.77 V.
// - Severe overvoltage clears only at power-on reset, not on enable drop.
// - Severe overvoltage detection stays active after other faults have latched.
// - Neither gate rises until the opposite gate is sensed below about 1 V.
// - During the start-up ramp select only the start-up sourcing current.
// - After start-up select the slew source, charging the ramp for rises.
// - The slew source sinks from the ramp node when the code falls.
// - Wait about 100 us after enable before starting the start-up ramp.
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor #(
    parameter int unsigned QUAL_CYCLES = rfs_pkg::QUAL_CYC,
    parameter int unsigned START_CYCLES = rfs_pkg::START_DELAY_CYC,
    parameter int unsigned SAMPLE_CYCLES = rfs_pkg::OC_SAMPLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic regulator_enable_input_i,
    input wire logic oc_over_i,
    input wire logic hard_short_i,
    input wire logic uv_below_ramp_i,
    input wire logic ov_above_ramp_i,
    input wire logic severe_ov_high_i,
    input wire logic output_sense_low_i,
    input wire logic high_side_sensed_low_i,
    input wire logic low_side_sensed_low_i,
    input wire logic pwm_high_i,
    input wire logic ramp_settled_i,
    input wire logic code_rise_i,
    input wire logic code_fall_i,
    output logic high_side_gate_o,
    output logic low_side_gate_o,
    output logic power_good_output_o,
    output logic overcurrent_fault_o,
    output logic overvoltage_fault_o,
    output logic undervoltage_fault_o,
    output logic severe_ov_fault_o,
    output rfs_pkg::rfs_src_t ramp_source_o,
    output logic ramp_charge_o,
    output logic ramp_discharge_o
);
    import rfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.
    localparam int unsigned NSYNC = 13;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {regulator_enable_input_i, oc_over_i, hard_short_i, uv_below_ramp_i,
                     ov_above_ramp_i, severe_ov_high_i, output_sense_low_i,
                     high_side_sensed_low_i, low_side_sensed_low_i, pwm_high_i,
                     ramp_settled_i, code_rise_i, code_fall_i};
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end
    logic en_s, oc_s, short_s, uv_s, ov_s, sov_hi_s, sov_lo_s;
    logic hs_low_s, ls_low_s, pwm_s, settled_s, rise_s, fall_s;
    assign {en_s, oc_s, short_s, uv_s, ov_s, sov_hi_s, sov_lo_s, hs_low_s, ls_low_s,
            pwm_s, settled_s, rise_s, fall_s} = sync2;

    ////////////////////////////////////////////////////////////////////////////
    // Enable sequencing: start delay, start-up ramp and run.
    rfs_state_t state, next_state;
    logic [TMR_W-1:0] start_tmr, next_start_tmr;

    always_comb begin
        next_state = state;
        next_start_tmr = start_tmr;
        if (!en_s) begin
            next_state = RFS_ST_OFF;
            next_start_tmr = '0;
        end else begin
            unique case (state)
                RFS_ST_OFF: begin
                    next_state = RFS_ST_DELAY;
                    next_start_tmr = '0;
                end
                RFS_ST_DELAY: begin
                    if (start_tmr == TMR_W'(START_CYCLES - 1)) begin
                        next_state = RFS_ST_RAMP;
                    end else begin
                        next_start_tmr = start_tmr + 1'b1;
                    end
                end
                RFS_ST_RAMP: begin
                    if (settled_s) begin
                        next_state = RFS_ST_RUN;
                    end
                end
                RFS_ST_RUN: begin
                    next_state = RFS_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= RFS_ST_OFF;
            start_tmr <= '0;
        end else begin
            state <= next_state;
            start_tmr <= next_start_tmr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sampled overcurrent counter and hard short latch.
    logic [TMR_W-1:0] sample_tmr, next_sample_tmr;
    logic [OC_CNT_W-1:0] oc_cnt, next_oc_cnt;
    logic oc_f, next_oc_f;
    logic sample_tick;

    always_comb begin
        next_sample_tmr = sample_tmr;
        next_oc_cnt = oc_cnt;
        next_oc_f = oc_f;
        sample_tick = (sample_tmr == TMR_W'(SAMPLE_CYCLES - 1));
        if (!en_s) begin
            next_oc_f = 1'b0;
            next_oc_cnt = '0;
            next_sample_tmr = '0;
        end else begin
            next_sample_tmr = sample_tick ? '0 : sample_tmr + 1'b1;
            if (sample_tick && !oc_f) begin
                if (oc_s) begin
                    next_oc_cnt = oc_cnt + 1'b1;
                    if (oc_cnt == OC_CNT_W'(OC_TRIP_COUNT - 1)) begin
                        next_oc_f = 1'b1;
                    end
                end else if (oc_cnt != '0) begin
                    next_oc_cnt = oc_cnt - 1'b1;
                end
            end
            if (short_s) begin
                next_oc_f = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_tmr <= '0;
            oc_cnt <= '0;
            oc_f <= 1'b0;
        end else begin
            sample_tmr <= next_sample_tmr;
            oc_cnt <= next_oc_cnt;
            oc_f <= next_oc_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Undervoltage and overvoltage qualification against the live ramp.
    logic [TMR_W-1:0] uv_tmr, next_uv_tmr;
    logic [TMR_W-1:0] ov_tmr, next_ov_tmr;
    logic uv_f, next_uv_f, ov_f, next_ov_f;

    always_comb begin
        next_uv_tmr = uv_tmr;
        next_ov_tmr = ov_tmr;
        next_uv_f = uv_f;
        next_ov_f = ov_f;
        if (!en_s) begin
            next_ov_f = 1'b0;
            next_uv_f = 1'b0;
            next_uv_tmr = '0;
            next_ov_tmr = '0;
        end else begin
            if (uv_s && state != RFS_ST_DELAY) begin
                next_uv_tmr = uv_tmr + 1'b1;
                if (uv_tmr == TMR_W'(QUAL_CYCLES - 1)) begin
                    next_uv_f = 1'b1;
                    next_uv_tmr = uv_tmr;
                end
            end else begin
                next_uv_tmr = '0;
            end
            if (ov_s && state != RFS_ST_DELAY) begin
                next_ov_tmr = ov_tmr + 1'b1;
                if (ov_tmr == TMR_W'(QUAL_CYCLES - 1)) begin
                    next_ov_f = 1'b1;
                    next_ov_tmr = ov_tmr;
                end
            end else begin
                next_ov_tmr = '0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            uv_tmr <= '0;
            ov_tmr <= '0;
            uv_f <= 1'b0;
            ov_f <= 1'b0;
        end else begin
            uv_tmr <= next_uv_tmr;
            ov_tmr <= next_ov_tmr;
            uv_f <= next_uv_f;
            ov_f <= next_ov_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Severe overvoltage latch and low gate hysteresis, cleared by reset only.
    logic sov_f, next_sov_f;
    logic ls_sov, next_ls_sov;

    always_comb begin
        next_sov_f = sov_f;
        next_ls_sov = ls_sov;
        if (sov_hi_s) begin
            next_sov_f = 1'b1;
            next_ls_sov = 1'b1;
        end else if (sov_lo_s) begin
            next_ls_sov = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sov_f <= 1'b0;
            ls_sov <= 1'b0;
        end else begin
            sov_f <= next_sov_f;
            ls_sov <= next_ls_sov;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate, power-good and ramp source outputs.
    logic fault_any;
    logic next_hs, next_ls, next_pg, next_chg, next_dis;
    rfs_src_t next_src;

    always_comb begin
        fault_any = oc_f || ov_f || uv_f;
        next_hs = 1'b0;
        next_ls = 1'b0;
        next_pg = 1'b0;
        next_chg = 1'b0;
        next_dis = 1'b0;
        next_src = RFS_SRC_NONE;
        if (sov_f) begin
            next_ls = ls_sov && hs_low_s && !high_side_gate_o;
        end else if (fault_any) begin
            next_ls = 1'b0;
        end else if (state == RFS_ST_RAMP || state == RFS_ST_RUN) begin
            next_hs = pwm_s && ls_low_s && !low_side_gate_o;
            next_ls = !pwm_s && hs_low_s && !high_side_gate_o;
            next_pg = (state == RFS_ST_RUN);
        end
        if (state == RFS_ST_RAMP) begin
            next_src = RFS_SRC_STARTUP;
            next_chg = 1'b1;
        end else if (state == RFS_ST_RUN) begin
            next_src = RFS_SRC_SLEW;
            next_chg = rise_s;
            next_dis = fall_s && !rise_s;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            high_side_gate_o <= 1'b0;
            low_side_gate_o <= 1'b0;
            power_good_output_o <= 1'b0;
            overcurrent_fault_o <= 1'b0;
            overvoltage_fault_o <= 1'b0;
            undervoltage_fault_o <= 1'b0;
            severe_ov_fault_o <= 1'b0;
            ramp_source_o <= RFS_SRC_NONE;
            ramp_charge_o <= 1'b0;
            ramp_discharge_o <= 1'b0;
        end else begin
            high_side_gate_o <= next_hs;
            low_side_gate_o <= next_ls;
            power_good_output_o <= next_pg;
            overcurrent_fault_o <= oc_f;
            overvoltage_fault_o <= ov_f;
            undervoltage_fault_o <= uv_f;
            severe_ov_fault_o <= sov_f;
            ramp_source_o <= next_src;
            ramp_charge_o <= next_chg;
            ramp_discharge_o <= next_dis;
        end
    end
endmodule : rfs_supervisor
`default_nettype wire

// ### tb/rfs_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_power_stage (
    input wire logic clk_i,
    input wire logic hs_gate_i,
    input wire logic ls_gate_i,
    output logic hs_low_o,
    output logic ls_low_o
);
    // A gate pin reads low only two cycles after its command falls.
    logic [1:0] hs_q = 2'h0;
    logic [1:0] ls_q = 2'h0;
    always @(posedge clk_i) begin
        hs_q <= {hs_q[0], hs_gate_i};
        ls_q <= {ls_q[0], ls_gate_i};
    end
    assign hs_low_o = !(hs_gate_i || hs_q != 2'h0);
    assign ls_low_o = !(ls_gate_i || ls_q != 2'h0);
endmodule : rfs_power_stage
`default_nettype wire

// ### tb/rfs_supervisor_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor_properties #(
    parameter int unsigned QUAL_CYCLES = 50,
    parameter int unsigned START_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic regulator_enable_input_i,
    input wire logic hard_short_i,
    input wire logic ov_above_ramp_i,
    input wire logic high_side_gate_o,
    input wire logic low_side_gate_o,
    input wire logic power_good_output_o,
    input wire logic overcurrent_fault_o,
    input wire logic overvoltage_fault_o,
    input wire logic undervoltage_fault_o,
    input wire logic severe_ov_fault_o,
    input wire rfs_pkg::rfs_src_t ramp_source_o
);
    import rfs_pkg::*;
    // Run lengths of the overvoltage condition and of enable.
    logic [23:0] ov_run, en_run, next_ov_run, next_en_run;
    logic any_f;
    assign any_f = overcurrent_fault_o || overvoltage_fault_o || undervoltage_fault_o;
    always_comb begin
        next_ov_run = ov_above_ramp_i ? ov_run + 24'h1 : 24'h0;
        next_en_run = regulator_enable_input_i ? en_run + 24'h1 : 24'h0;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ov_run <= 24'h0;
            en_run <= 24'h0;
        end else begin
            ov_run <= next_ov_run;
            en_run <= next_en_run;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_fault_off; any_f && !severe_ov_fault_o |->
        !high_side_gate_o && !low_side_gate_o && !power_good_output_o; endproperty
    a_fault_off: assert property (p_fault_off) else $error("gates on in fault");
    property p_sev_off; severe_ov_fault_o |-> !high_side_gate_o && !power_good_output_o; endproperty
    a_sev_off: assert property (p_sev_off) else $error("severe fault outputs");
    property p_sev_hold; severe_ov_fault_o |=> severe_ov_fault_o; endproperty
    a_sev_hold: assert property (p_sev_hold) else $error("severe fault lost");
    property p_overlap; !(high_side_gate_o && low_side_gate_o); endproperty
    a_overlap: assert property (p_overlap) else $error("both gates high");
    property p_short; (hard_short_i && regulator_enable_input_i) [*8] |->
        ##[0:392] overcurrent_fault_o; endproperty
    a_short: assert property (p_short) else $error("short not latched");
    property p_clear; !regulator_enable_input_i [*6] |-> !any_f; endproperty
    a_clear: assert property (p_clear) else $error("fault kept");
    property p_ov_qual; $rose(overvoltage_fault_o) |-> ov_run >= QUAL_CYCLES; endproperty
    a_ov_qual: assert property (p_ov_qual) else $error("early overvoltage");
    property p_start; $changed(ramp_source_o) && ramp_source_o == RFS_SRC_STARTUP |->
        en_run >= START_CYCLES; endproperty
    a_start: assert property (p_start) else $error("ramp too early");
    c_sev: cover property (severe_ov_fault_o && low_side_gate_o);
    c_ov: cover property ($rose(overvoltage_fault_o));
    c_oc: cover property ($rose(overcurrent_fault_o));
endmodule : rfs_supervisor_properties
bind rfs_supervisor rfs_supervisor_properties #(.QUAL_CYCLES(QUAL_CYCLES),
    .START_CYCLES(START_CYCLES)) i_rfs_supervisor_properties (.clk_i(clk_i), .rst_i(rst_i),
    .regulator_enable_input_i(regulator_enable_input_i), .hard_short_i(hard_short_i),
    .ov_above_ramp_i(ov_above_ramp_i), .high_side_gate_o(high_side_gate_o),
    .low_side_gate_o(low_side_gate_o), .power_good_output_o(power_good_output_o),
    .overcurrent_fault_o(overcurrent_fault_o), .overvoltage_fault_o(overvoltage_fault_o),
    .undervoltage_fault_o(undervoltage_fault_o), .severe_ov_fault_o(severe_ov_fault_o),
    .ramp_source_o(ramp_source_o));
`default_nettype wire

// ### tb/rfs_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module rfs_supervisor_test;
    import rfs_pkg::*;
    localparam int QUAL = 50;
    localparam int START = 20;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, oc = 1'b0, shrt = 1'b0, uv = 1'b0, ov = 1'b0;
    logic sev = 1'b0, olow = 1'b0, pwm = 1'b0, setl = 1'b0, rise = 1'b0, fall = 1'b0;
    logic hs, ls, pg, f_oc, f_ov, f_uv, f_sev, chg, dis, hsl, lsl;
    rfs_src_t src;
    int checks = 0, mismatches = 0, ticks = 0, n;
    rfs_supervisor #(.QUAL_CYCLES(QUAL), .START_CYCLES(START), .SAMPLE_CYCLES(10)) i_rfs_supervisor (
        .clk_i(clk), .rst_i(rst), .regulator_enable_input_i(en), .oc_over_i(oc),
        .hard_short_i(shrt), .uv_below_ramp_i(uv), .ov_above_ramp_i(ov), .severe_ov_high_i(sev),
        .output_sense_low_i(olow), .high_side_sensed_low_i(hsl), .low_side_sensed_low_i(lsl),
        .pwm_high_i(pwm), .ramp_settled_i(setl), .code_rise_i(rise), .code_fall_i(fall),
        .high_side_gate_o(hs), .low_side_gate_o(ls), .power_good_output_o(pg),
        .overcurrent_fault_o(f_oc), .overvoltage_fault_o(f_ov), .undervoltage_fault_o(f_uv),
        .severe_ov_fault_o(f_sev), .ramp_source_o(src), .ramp_charge_o(chg), .ramp_discharge_o(dis));
    rfs_power_stage i_rfs_power_stage (.clk_i(clk), .hs_gate_i(hs), .ls_gate_i(ls),
        .hs_low_o(hsl), .ls_low_o(lsl));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        pwm <= (ticks % 32) < 16;
        ticks <= ticks + 1;
        if (ticks == 5000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic cyc(input int k); repeat (k) @(posedge clk); endtask : cyc
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic run_up();
        en <= 1'b0;
        setl <= 1'b0;
        cyc(8);
        `CHK(f_oc | f_ov | f_uv, 1'b0)
        en <= 1'b1;
        for (n = 0; n < 100 && src !== RFS_SRC_STARTUP; n++) @(posedge clk);
        `CHK(n >= START && n <= START + 10, 1'b1)
        `CHK({chg, dis, pg}, 3'h4)
        setl <= 1'b1;
        cyc(8);
        `CHK({src, pg}, {RFS_SRC_SLEW, 1'b1})
        for (n = 0; n < 40 && hs !== 1'b1; n++) @(posedge clk);
        `CHK(hs, 1'b1)
        $display("run_up done");
    endtask : run_up
    task automatic t_slew();
        rise <= 1'b1;
        cyc(6);
        `CHK({chg, dis}, 2'h2)
        rise <= 1'b0;
        fall <= 1'b1;
        cyc(6);
        `CHK({chg, dis}, 2'h1)
        fall <= 1'b0;
        $display("t_slew done");
    endtask : t_slew
    task automatic t_oc();
        oc <= 1'b1;
        cyc(55);
        oc <= 1'b0;
        cyc(45);
        oc <= 1'b1;
        cyc(50);
        `CHK(f_oc, 1'b0)
        for (n = 0; n < 100 && f_oc !== 1'b1; n++) @(posedge clk);
        `CHK({f_oc, hs, ls, pg}, 4'h8)
        oc <= 1'b0;
        $display("t_oc done");
    endtask : t_oc
    task automatic t_oc_clear();
        oc <= 1'b1;
        cyc(62);
        `CHK(f_oc, 1'b0)
        for (n = 0; n < 40 && f_oc !== 1'b1; n++) @(posedge clk);
        `CHK(f_oc, 1'b1)
        oc <= 1'b0;
        $display("t_oc_clear done");
    endtask : t_oc_clear
    task automatic t_qual(input bit sel);
        uv <= sel;
        ov <= !sel;
        cyc(QUAL - 5);
        {uv, ov} <= 2'h0;
        cyc(2);
        uv <= sel;
        ov <= !sel;
        cyc(QUAL - 5);
        `CHK({f_ov, f_uv}, 2'h0)
        for (n = 0; n < 60 && (f_ov | f_uv) !== 1'b1; n++) @(posedge clk);
        `CHK({f_ov, f_uv, hs, ls, pg}, {!sel, sel, 3'h0})
        {uv, ov} <= 2'h0;
        $display("t_qual done");
    endtask : t_qual
    task automatic t_short();
        shrt <= 1'b1;
        cyc(20);
        `CHK(f_oc, 1'b1)
        shrt <= 1'b0;
        $display("t_short done");
    endtask : t_short
    task automatic t_severe();
        sev <= 1'b1;
        cyc(8);
        `CHK({f_sev, hs, pg, ls}, 4'h9)
        sev <= 1'b0;
        cyc(8);
        `CHK(ls, 1'b1)
        olow <= 1'b1;
        cyc(8);
        `CHK(ls, 1'b0)
        olow <= 1'b0;
        sev <= 1'b1;
        cyc(8);
        `CHK(ls, 1'b1)
        sev <= 1'b0;
        en <= 1'b0;
        cyc(10);
        `CHK(f_sev, 1'b1)
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        `CHK(f_sev, 1'b0)
        $display("t_severe done");
    endtask : t_severe
    initial begin
        cyc(8);
        rst <= 1'b0;
        run_up();
        t_slew();
        t_oc();
        run_up();
        t_oc_clear();
        run_up();
        t_qual(1'b0);
        run_up();
        t_qual(1'b1);
        run_up();
        t_short();
        t_severe();
        run_up();
        final_report();
    end
endmodule : rfs_supervisor_test
`default_nettype wire
